// ---- rtl/clock_mult_pkg.sv ----
// constants, field layout and types of the clock multiplier control block
// Operation
// - output is four times the input clock times the selected scale factor
// - input is external oscillator, internal halved, or external halved
// - base outputs are internal times two, external times two, external times four
// - software polls ready; device raises ready only once stabilized
// - slow input gives four fast pulses per input edge, then holds
// - initialize is zero when enabling; writing one once enabled starts initialization
// - ready bit five is read-only and reports lock status
// - scaling code 000 gives factor one, code 100 gives one half
package clock_mult_pkg;
  // ==========================================================================
  // register map
  localparam logic [7:0] CLOCK_MULT_CONTROL_ADDR = 8'hAB;
  localparam logic [7:0] CLOCK_MULT_CONTROL_RESET = 8'h00;
  localparam int ENABLE_BIT = 7;
  localparam int INIT_BIT = 6;
  localparam int READY_BIT = 5;
  localparam int SCALE_LSB = 2;
  localparam int SELECT_LSB = 0;
  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int LOCK_TIME_NS = 1000;
  localparam int LOCK_CYCLES = (LOCK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // credits per input edge: four pulses times the scale numerator two
  localparam logic [5:0] EDGE_CREDITS = 6'h08;
  localparam logic [5:0] CREDIT_MAX = 6'h30;
  // ==========================================================================
  // field encodings
  typedef enum logic [1:0] {
    SEL_INT_HALF = 2'b00,
    SEL_EXT_FULL = 2'b01,
    SEL_EXT_HALF = 2'b10,
    SEL_RESERVED = 2'b11
  } input_select_type;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_LOCKING = 2'b01,
    ST_LOCKED = 2'b10
  } lock_state_type;
  typedef struct packed {
    logic mult_enable;
    logic mult_initialize;
    logic [2:0] mult_output_scale;
    input_select_type mult_input_select;
  } control_type;
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } sfr_req_type;
endpackage : clock_mult_pkg

// ---- rtl/clock_multiplier_control.sv ----
// control register, lock sequencing and pulse generation of the clock multiplier
`timescale 1ns/10ps
module clock_multiplier_control
  import clock_mult_pkg::*;
#(
  parameter int LOCK_COUNT = LOCK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire sfr_req_type sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic int_osc,
  input wire logic ext_osc,
  output logic mult_ready_flag,
  output logic mult_clk_pulse
);
  // ==========================================================================
  // state
  control_type ctrl_r, ctrl_nxt;
  lock_state_type state_r, state_nxt;
  logic [12:0] lock_cnt_r, lock_cnt_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic ready_r, ready_nxt;
  logic int_q_r, int_q_nxt, ext_q_r, ext_q_nxt;
  logic half_r, half_nxt;
  logic [5:0] credit_r, credit_nxt;
  logic pulse_r, pulse_nxt;
  logic wr_hit, init_req, src_rise, src_level, src_prev;
  logic [5:0] denom;
  logic [5:0] credit_sum;

  assign wr_hit = sfr_req.wr && (sfr_req.addr == CLOCK_MULT_CONTROL_ADDR);
  // initialize only counts while already enabled
  assign init_req = wr_hit && ctrl_r.mult_enable && sfr_req.wdata[ENABLE_BIT] && sfr_req.wdata[INIT_BIT];

  // ==========================================================================
  // control register and lock sequencing
  always_comb begin
    ctrl_nxt = ctrl_r;
    state_nxt = state_r;
    lock_cnt_nxt = lock_cnt_r;
    rdata_nxt = 8'h00;
    if (wr_hit) begin
      // ready bit is not stored from the write data
      ctrl_nxt.mult_enable = sfr_req.wdata[ENABLE_BIT];
      ctrl_nxt.mult_initialize = sfr_req.wdata[INIT_BIT];
      ctrl_nxt.mult_output_scale = sfr_req.wdata[SCALE_LSB +: 3];
      ctrl_nxt.mult_input_select = input_select_type'(sfr_req.wdata[SELECT_LSB +: 2]);
    end
    case (state_r)
      ST_OFF: begin
        if (init_req) begin
          state_nxt = ST_LOCKING;
          lock_cnt_nxt = 13'h0000;
        end
      end
      ST_LOCKING: begin
        if (lock_cnt_r == 13'(LOCK_COUNT - 1)) begin
          state_nxt = ST_LOCKED;
        end else begin
          lock_cnt_nxt = lock_cnt_r + 13'h0001;
        end
      end
      ST_LOCKED: begin
        if (init_req) begin
          state_nxt = ST_LOCKING;
          lock_cnt_nxt = 13'h0000;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
    // clearing enable drops lock at once
    if (!ctrl_nxt.mult_enable) begin
      state_nxt = ST_OFF;
    end
    ready_nxt = (state_nxt == ST_LOCKED);
    if (sfr_req.rd && sfr_req.addr == CLOCK_MULT_CONTROL_ADDR) begin
      rdata_nxt = {ctrl_r.mult_enable, ctrl_r.mult_initialize, ready_r,
                   ctrl_r.mult_output_scale, ctrl_r.mult_input_select};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      // the stored fields skip the read-only ready bit
      ctrl_r <= control_type'({CLOCK_MULT_CONTROL_RESET[7:6], CLOCK_MULT_CONTROL_RESET[4:0]});
      state_r <= ST_OFF;
      lock_cnt_r <= 13'h0000;
      rdata_r <= 8'h00;
      ready_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      state_r <= state_nxt;
      lock_cnt_r <= lock_cnt_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
    end
  end

  // ==========================================================================
  // input selection and scaling
  always_comb begin
    case (ctrl_r.mult_input_select)
      SEL_INT_HALF: begin
        src_level = int_osc;
        src_prev = int_q_r;
      end
      SEL_EXT_FULL, SEL_EXT_HALF: begin
        src_level = ext_osc;
        src_prev = ext_q_r;
      end
      default: begin
        src_level = 1'b0;
        src_prev = 1'b0;
      end
    endcase
    // factor is 2/denom
    case (ctrl_r.mult_output_scale)
      3'b000, 3'b001: denom = 6'h02;
      3'b010, 3'b011: denom = 6'h03;
      3'b100: denom = 6'h04;
      3'b101: denom = 6'h05;
      3'b110: denom = 6'h06;
      3'b111: denom = 6'h07;
      default: denom = 6'h02;
    endcase
  end

  // ==========================================================================
  // pulse generation: each counted edge buys four pulses times the factor
  always_comb begin
    int_q_nxt = int_osc;
    ext_q_nxt = ext_osc;
    half_nxt = half_r;
    src_rise = 1'b0;
    if (src_level && !src_prev) begin
      if (ctrl_r.mult_input_select == SEL_EXT_FULL) begin
        src_rise = 1'b1;
      end else begin
        half_nxt = !half_r;
        src_rise = half_r;
      end
    end
    credit_sum = (src_rise && credit_r <= CREDIT_MAX) ? credit_r + EDGE_CREDITS : credit_r;
    pulse_nxt = 1'b0;
    credit_nxt = credit_sum;
    if (credit_sum >= denom) begin
      pulse_nxt = 1'b1;
      credit_nxt = credit_sum - denom;
    end
    if (!ready_r || ctrl_r.mult_input_select == SEL_RESERVED) begin
      credit_nxt = 6'h00;
      pulse_nxt = 1'b0;
      half_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      int_q_r <= 1'b0;
      ext_q_r <= 1'b0;
      half_r <= 1'b0;
      credit_r <= 6'h00;
      pulse_r <= 1'b0;
    end else begin
      int_q_r <= int_q_nxt;
      ext_q_r <= ext_q_nxt;
      half_r <= half_nxt;
      credit_r <= credit_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  assign mult_ready_flag = ready_r;
  assign mult_clk_pulse = pulse_r;

  // ==========================================================================
  // checks
  sequence init_seq;
    init_req && state_r != ST_LOCKING;
  endsequence
  sequence locked_seq;
    ready_r;
  endsequence

  ready_after_lock_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    init_seq ##1 (ctrl_r.mult_enable && !wr_hit) [*2] |-> !ready_r)
    else $error("ready rose before lock time");
  ready_needs_enable_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ready_r |-> ctrl_r.mult_enable)
    else $error("ready while disabled");
  init_starts_lock_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    init_req |=> state_r == ST_LOCKING)
    else $error("initialize did not start locking");
  ready_read_only_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_hit && sfr_req.wdata[ENABLE_BIT] && !sfr_req.wdata[INIT_BIT] && ctrl_r.mult_enable && state_r != ST_LOCKING
    |=> mult_ready_flag == $past(mult_ready_flag))
    else $error("write changed ready");
  ready_readback_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    sfr_req.rd && sfr_req.addr == CLOCK_MULT_CONTROL_ADDR |=> sfr_rdata[READY_BIT] == $past(ready_r))
    else $error("read ready mismatch");
  no_pulse_unlocked_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !ready_r |=> !mult_clk_pulse)
    else $error("pulse while unlocked");
  four_pulses_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    locked_seq and (credit_r == 6'h00 && src_rise && denom == 6'h02 && ready_nxt) |=> mult_clk_pulse [*4])
    else $error("factor one edge did not give four pulses");
  scale_half_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    locked_seq and (credit_r == 6'h00 && src_rise && ctrl_r.mult_output_scale == 3'b100 && ready_nxt)
    |=> mult_clk_pulse [*2] ##1 !mult_clk_pulse)
    else $error("scale 100 not one half");
  reserved_quiet_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ctrl_r.mult_input_select == SEL_RESERVED |=> !mult_clk_pulse)
    else $error("pulse from reserved select");
endmodule : clock_multiplier_control

// ---- dv/tb_top.sv ----
// self-checking bench for the clock multiplier control block
`timescale 1ns/10ps
module tb_top;
  import clock_mult_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  sfr_req_type req = '0;
  logic int_osc = 1'b0;
  logic ext_osc = 1'b0;
  logic [7:0] sfr_rdata;
  logic mult_ready_flag;
  logic mult_clk_pulse;
  logic [7:0] exp_q[$];
  logic [7:0] pulse_cnt = 8'h00;
  logic chk = 1'b0;
  logic [7:0] f;
  logic [7:0] e;
  logic [15:0] w;
  int miscompares = 0;
  int comparisons = 0;
  int seed = 80;
  int i;
  int k;
  // ==========================================================================
  // cases: source mask, input edges, scale code, select code
  logic [15:0] cases [11] = '{16'h2201, 16'h2211,
    16'h2321, 16'h2331, 16'h2441, 16'h2551, 16'h2661, 16'h2771,
    16'h1400, 16'h2402, 16'h2403};
  // sources stay slow enough that every setting keeps the output in range

  always #20 clk_sys = ~clk_sys;

  clock_multiplier_control #(.LOCK_COUNT(3)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .sfr_req(req), .sfr_rdata(sfr_rdata), .int_osc(int_osc), .ext_osc(ext_osc),
    .mult_ready_flag(mult_ready_flag), .mult_clk_pulse(mult_clk_pulse));

  // ==========================================================================
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] expv);
    comparisons++;
    if (seen !== expv) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge clk_sys);
    req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    @(negedge clk_sys);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge clk_sys);
    req.rd = 1'b0;
  endtask : rd

  // ==========================================================================
  // monitor: read data and pulse counts against the oldest note
  always @(posedge clk_sys) begin
    #1;
    if (mult_clk_pulse === 1'b1) pulse_cnt = pulse_cnt + 8'h01;
    if (req.rd === 1'b1 || chk) begin
      e = exp_q.pop_front();
      check(req.rd ? sfr_rdata : pulse_cnt, e);
      if (req.rd === 1'b1 && req.addr == 8'hAB) begin
        check({7'h00, mult_ready_flag}, {7'h00, e[5]});
      end
      if (chk) pulse_cnt = 8'h00;
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    report_and_stop();
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    rd(8'hAB, 8'h00);
    for (i = 0; i < 11; i++) begin
      w = cases[i];
      f = {3'b000, w[6:4], w[1:0]};
      wr(8'hAB, 8'h00);
      rd(8'hAB, 8'h00);
      wr(8'hAB, {6'h00, w[1:0]});
      wr(8'hAB, f | 8'h20);
      wr(8'hAA, 8'($random(seed)));
      rd(8'hAA, 8'h00);
      rd(8'hAB, f);
      wr(8'hAB, f | 8'h80);
      wr(8'hAB, f | 8'hA0);
      rd(8'hAB, f | 8'h80);
      repeat (5000 / CLK_PERIOD_NS + 5) @(negedge clk_sys);
      wr(8'hAB, f | 8'hC0);
      rd(8'hAB, f | 8'hC0);
      k = 0;
      while (mult_ready_flag !== 1'b1 && k < 100) begin
        @(negedge clk_sys);
        k++;
      end
      rd(8'hAB, f | 8'hE0);
      wr(8'hAB, f | 8'h80);
      rd(8'hAB, f | 8'hA0);
      repeat (w[11:8]) begin
        @(negedge clk_sys);
        int_osc = w[12];
        ext_osc = w[13];
        repeat (2) @(negedge clk_sys);
        int_osc = 1'b0;
        ext_osc = 1'b0;
        repeat (12 + ($random(seed) & 7)) @(negedge clk_sys);
      end
      exp_q.push_back(w[1:0] == 2'b11 ? 8'h00 : 8'h08);
      @(negedge clk_sys);
      chk = 1'b1;
      @(negedge clk_sys);
      chk = 1'b0;
      $display("case %0d done", i);
    end
    report_and_stop();
  end
endmodule : tb_top
